// [common/ccpu_pkg.sv]
// Constants, types and mode decoding for the capture/compare/PWM unit pair.
// Assumes an 8-bit register port and 16-bit timer counts from outside.
package ccpu_pkg;

  // **********************************************************************
  // Register map (word per address, 8-bit data)
  // **********************************************************************
  localparam logic [3:0] OFS_CTRL_ONE = 4'h0;  // unit_control, unit one
  localparam logic [3:0] OFS_LOW_ONE  = 4'h1;  // unit_one_value_low
  localparam logic [3:0] OFS_HIGH_ONE = 4'h2;  // unit_one_value_high
  localparam logic [3:0] OFS_CTRL_TWO = 4'h3;  // unit_control, unit two
  localparam logic [3:0] OFS_LOW_TWO  = 4'h4;  // unit_two_value_low
  localparam logic [3:0] OFS_HIGH_TWO = 4'h5;  // unit_two_value_high
  localparam logic [3:0] OFS_FLAGS    = 4'h6;  // Event flags, write 1 clears
  localparam logic [3:0] OFS_ENABLES  = 4'h7;  // Event interrupt enables

  // **********************************************************************
  // Fields and reset values
  // **********************************************************************
  localparam int         DUTY_LSB     = 4;      // duty_low_bits at [5:4]
  localparam logic [5:0] CTRL_RST     = 6'h00;
  localparam logic [15:0] VALUE_RST   = 16'h0000;
  localparam logic [9:0] DUTY_RST     = 10'h000;
  localparam logic [3:0] PRESC_FOUR   = 4'h3;   // Last count of four
  localparam logic [3:0] PRESC_SIXTN  = 4'hF;   // Last count of sixteen

  // **********************************************************************
  // Mode field codes
  // **********************************************************************
  localparam logic [3:0] MODE_OFF     = 4'h0;
  localparam logic [3:0] MODE_TOGGLE  = 4'h2;
  localparam logic [3:0] MODE_CAP_FAL = 4'h4;
  localparam logic [3:0] MODE_CAP_RIS = 4'h5;
  localparam logic [3:0] MODE_CAP_R4  = 4'h6;
  localparam logic [3:0] MODE_CAP_R16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_SW  = 4'hA;
  localparam logic [3:0] MODE_CMP_TRG = 4'hB;

  typedef enum logic [4:0] {
    CLS_OFF      = 5'h01,
    CLS_CAPTURE  = 5'h02,
    CLS_COMPARE  = 5'h04,
    CLS_PWM      = 5'h08,
    CLS_RESERVED = 5'h10
  } ccpu_class_e;

  // Whole state of the unit pair
  typedef struct packed {
    logic [1:0][5:0]  ctrl;
    logic [1:0][15:0] value;
    logic [1:0][3:0]  presc;
    logic [1:0][9:0]  duty;
    logic [1:0]       flag;
    logic [1:0]       irq_en;
    logic [1:0]       sync_a;
    logic [1:0]       sync_b;
    logic [1:0]       pin_prev;
    logic [1:0]       out_latch;
    logic [1:0]       match_prev;
    logic [1:0]       trig;
    logic             clr_first;
    logic             clr_second;
    logic             adc_start;
    logic [7:0]       rdata;
  } ccpu_state_s;

  // Sorts a mode field value into its operating class
  function automatic ccpu_class_e mode_class(input logic [3:0] mode);
    ccpu_class_e cls;
    cls = CLS_RESERVED;
    case (mode)
      MODE_OFF: cls = CLS_OFF;
      MODE_TOGGLE, MODE_CMP_SET, MODE_CMP_CLR, MODE_CMP_SW, MODE_CMP_TRG:
        cls = CLS_COMPARE;
      MODE_CAP_FAL, MODE_CAP_RIS, MODE_CAP_R4, MODE_CAP_R16:
        cls = CLS_CAPTURE;
      4'hC, 4'hD, 4'hE, 4'hF: cls = CLS_PWM;
      default: cls = CLS_RESERVED;
    endcase
    return cls;
  endfunction

endpackage

// [rtl/ccpu_top.sv]
// Two capture/compare/PWM units with their registers, pin logic and triggers.
// Assumes timer counts, timer writes and the PWM period event arrive
// synchronous to clk_in; the unit pins are synchronised here.
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module ccpu_top (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  input  wire logic [15:0] first_timer_count_in,
  input  wire logic [15:0] second_timer_count_in,
  input  wire logic        first_timer_write_in,
  input  wire logic        second_timer_write_in,
  input  wire logic [1:0]  timebase_select_in,
  input  wire logic        pwm_period_in,
  input  wire logic        adc_enable_in,
  input  wire logic [1:0]  unit_pin_in,
  input  wire logic [1:0]  port_data_in,
  input  wire logic [1:0]  port_direction_in,
  output logic      [1:0]  unit_pin_out,
  output logic      [1:0]  unit_pin_oe_out,
  output logic      [1:0]  unit_event_flag_out,
  output logic      [1:0]  unit_event_irq_out,
  output logic      [1:0]  match_trigger_out,
  output logic             first_timer_clear_out,
  output logic             second_timer_clear_out,
  output logic             adc_start_out,
  output logic      [9:0]  pwm_duty_one_out,
  output logic      [9:0]  pwm_duty_two_out
);

  // **********************************************************************
  // State and per-unit compare terms
  // **********************************************************************
  ccpu_pkg::ccpu_state_s st_q;
  ccpu_pkg::ccpu_state_s st_d;
  logic [1:0]            use_second;
  logic [1:0][15:0]      tb;
  logic [1:0]            match;
  logic [1:0]            hit;
  logic [1:0]            is_cmp;
  logic [1:0]            drives_pin;

  // Timebase pick per unit
  assign use_second[0] = timebase_select_in[1];
  assign use_second[1] = timebase_select_in[1] | timebase_select_in[0];

  // Continuous compare against the selected timer, acted on at match entry
  for (genvar g = 0; g < 2; g++) begin : g_unit
    assign tb[g] = use_second[g] ? second_timer_count_in
                                 : first_timer_count_in;
    assign match[g]  = (st_q.value[g] == tb[g]);
    assign is_cmp[g] = (ccpu_pkg::mode_class(st_q.ctrl[g][3:0])
                        == ccpu_pkg::CLS_COMPARE);
    assign hit[g]    = match[g] & ~st_q.match_prev[g] & is_cmp[g];
    assign drives_pin[g] = is_cmp[g]
                           & (st_q.ctrl[g][3:0] != ccpu_pkg::MODE_CMP_SW);
  end

  // **********************************************************************
  // Next state
  // **********************************************************************
  // Register access, capture, compare and PWM duty staging for both units
  always_comb begin
    logic [3:0]            mode_v;
    logic                  rise_v;
    logic                  fall_v;
    logic                  cap_v;
    logic                  set_v;
    logic                  clr_v;
    logic [3:0]            last_v;
    logic [3:0]            a_ctrl;
    logic [3:0]            a_low;
    logic [3:0]            a_high;
    ccpu_pkg::ccpu_class_e cls_v;
    mode_v = 4'h0;
    rise_v = 1'b0;
    fall_v = 1'b0;
    cap_v  = 1'b0;
    set_v  = 1'b0;
    clr_v  = 1'b0;
    last_v = 4'h0;
    a_ctrl = 4'h0;
    a_low  = 4'h0;
    a_high = 4'h0;
    cls_v  = ccpu_pkg::CLS_OFF;
    st_d   = st_q;
    st_d.clr_first  = 1'b0;
    st_d.clr_second = 1'b0;
    st_d.adc_start  = 1'b0;
    for (int u = 0; u < 2; u++) begin
      a_ctrl = (u == 0) ? ccpu_pkg::OFS_CTRL_ONE : ccpu_pkg::OFS_CTRL_TWO;
      a_low  = (u == 0) ? ccpu_pkg::OFS_LOW_ONE  : ccpu_pkg::OFS_LOW_TWO;
      a_high = (u == 0) ? ccpu_pkg::OFS_HIGH_ONE : ccpu_pkg::OFS_HIGH_TWO;
      mode_v = st_q.ctrl[u][3:0];
      cls_v  = ccpu_pkg::mode_class(mode_v);
      cap_v  = 1'b0;
      // Pin synchroniser; edges seen whatever the pin direction
      st_d.sync_a[u]   = unit_pin_in[u];
      st_d.sync_b[u]   = st_q.sync_a[u];
      st_d.pin_prev[u] = st_q.sync_b[u];
      rise_v = st_q.sync_b[u] & ~st_q.pin_prev[u];
      fall_v = ~st_q.sync_b[u] & st_q.pin_prev[u];
      st_d.match_prev[u] = match[u];
      st_d.trig[u] = 1'b0;
      case (cls_v)
        ccpu_pkg::CLS_CAPTURE: begin
          case (mode_v)
            ccpu_pkg::MODE_CAP_FAL: cap_v = fall_v;
            ccpu_pkg::MODE_CAP_RIS: cap_v = rise_v;
            default: begin
              // Count survives a switch between prescale settings
              last_v = (mode_v == ccpu_pkg::MODE_CAP_R4)
                       ? ccpu_pkg::PRESC_FOUR : ccpu_pkg::PRESC_SIXTN;
              if (rise_v) begin
                if (st_q.presc[u] >= last_v) begin
                  cap_v = 1'b1;
                  st_d.presc[u] = 4'h0;
                end else begin
                  st_d.presc[u] = st_q.presc[u] + 4'h1;
                end
              end
            end
          endcase
        end
        ccpu_pkg::CLS_COMPARE: begin
          st_d.presc[u] = 4'h0;
          if (hit[u]) begin
            case (mode_v)
              ccpu_pkg::MODE_TOGGLE:
                st_d.out_latch[u] = ~st_q.out_latch[u];
              ccpu_pkg::MODE_CMP_SET: st_d.out_latch[u] = 1'b1;
              ccpu_pkg::MODE_CMP_CLR: st_d.out_latch[u] = 1'b0;
              ccpu_pkg::MODE_CMP_TRG: begin
                st_d.trig[u] = 1'b1;
                // Clear the timer this unit times against
                if (use_second[u]) begin
                  st_d.clr_second = 1'b1;
                end else begin
                  st_d.clr_first = 1'b1;
                end
                if (u == 1) begin
                  st_d.adc_start = adc_enable_in;
                end
              end
              default: ;
            endcase
          end
        end
        ccpu_pkg::CLS_PWM: begin
          st_d.presc[u] = 4'h0;
          if (pwm_period_in) begin
            st_d.duty[u] = {st_q.value[u][7:0],
                            st_q.ctrl[u][ccpu_pkg::DUTY_LSB +: 2]};
          end
        end
        ccpu_pkg::CLS_OFF: begin
          st_d.presc[u]     = 4'h0;
          st_d.out_latch[u] = 1'b0;
        end
        default: begin
          st_d.presc[u] = 4'h0;
        end
      endcase
      // Software writes to this unit
      if (reg_wr_in && reg_addr_in == a_ctrl) begin
        st_d.ctrl[u] = reg_wdata_in[5:0];
        if (reg_wdata_in[3:0] != mode_v) begin
          case (reg_wdata_in[3:0])
            ccpu_pkg::MODE_OFF: begin
              st_d.out_latch[u] = 1'b0;
              st_d.presc[u]     = 4'h0;
            end
            ccpu_pkg::MODE_CMP_SET: st_d.out_latch[u] = 1'b0;
            ccpu_pkg::MODE_CMP_CLR: st_d.out_latch[u] = 1'b1;
            default: ;
          endcase
        end
      end
      if (reg_wr_in && reg_addr_in == a_low) begin
        st_d.value[u][7:0] = reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == a_high) begin
        st_d.value[u][15:8] = reg_wdata_in;
      end
      // Capture overwrites any value, read or not, and beats a write
      if (cap_v) begin
        st_d.value[u] = tb[u];
      end
      // Flag: hardware set wins over a software clear
      set_v = cap_v | hit[u];
      clr_v = reg_wr_in && reg_addr_in == ccpu_pkg::OFS_FLAGS
              && reg_wdata_in[u];
      st_d.flag[u] = (st_q.flag[u] & ~clr_v) | set_v;
    end
    if (reg_wr_in && reg_addr_in == ccpu_pkg::OFS_ENABLES) begin
      st_d.irq_en = reg_wdata_in[1:0];
    end
    // Read data stands for the one cycle after the read strobe
    st_d.rdata = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        ccpu_pkg::OFS_CTRL_ONE: st_d.rdata = {2'h0, st_q.ctrl[0]};
        ccpu_pkg::OFS_LOW_ONE:  st_d.rdata = st_q.value[0][7:0];
        ccpu_pkg::OFS_HIGH_ONE: st_d.rdata = st_q.value[0][15:8];
        ccpu_pkg::OFS_CTRL_TWO: st_d.rdata = {2'h0, st_q.ctrl[1]};
        ccpu_pkg::OFS_LOW_TWO:  st_d.rdata = st_q.value[1][7:0];
        ccpu_pkg::OFS_HIGH_TWO: st_d.rdata = st_q.value[1][15:8];
        ccpu_pkg::OFS_FLAGS:    st_d.rdata = {6'h00, st_q.flag};
        ccpu_pkg::OFS_ENABLES:  st_d.rdata = {6'h00, st_q.irq_en};
        default:                st_d.rdata = 8'h00;
      endcase
    end
  end

  // **********************************************************************
  // State register
  // **********************************************************************
  // Whole state cleared by the asynchronous reset
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q       <= '0;
      st_q.ctrl  <= {2{ccpu_pkg::CTRL_RST}};
      st_q.value <= {2{ccpu_pkg::VALUE_RST}};
      st_q.duty  <= {2{ccpu_pkg::DUTY_RST}};
    end else begin
      st_q <= st_d;
    end
  end

  // **********************************************************************
  // Outputs
  // **********************************************************************
  // Pin mux: compare latch in driving modes, else the port latch
  assign unit_pin_out        = (drives_pin & st_q.out_latch)
                               | (~drives_pin & port_data_in);
  assign unit_pin_oe_out     = ~port_direction_in;
  assign unit_event_flag_out = st_q.flag;
  assign unit_event_irq_out  = st_q.flag & st_q.irq_en;
  assign match_trigger_out   = st_q.trig;
  // A software timer write in the same cycle suppresses the clear
  assign first_timer_clear_out  = st_q.clr_first
                                  & ~first_timer_write_in;
  assign second_timer_clear_out = st_q.clr_second
                                  & ~second_timer_write_in;
  assign adc_start_out       = st_q.adc_start;
  assign pwm_duty_one_out    = st_q.duty[0];
  assign pwm_duty_two_out    = st_q.duty[1];
  assign reg_rdata_out       = st_q.rdata;

  // **********************************************************************
  // Assertions
  // **********************************************************************
  a_presc_held_clear: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (st_q.ctrl[0][3:2] != 2'h1) |=> (st_q.presc[0] == 4'h0))
    else $error("prescaler not clear outside capture");

  a_capture_copies_timer: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (st_q.ctrl[1][3:0] == ccpu_pkg::MODE_CAP_RIS && st_q.sync_b[1]
     && !st_q.pin_prev[1])
    |=> (st_q.value[1] == $past(tb[1])) && st_q.flag[1])
    else $error("capture did not copy timer count");

  a_flag_sticky: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (st_q.flag[0] && !(reg_wr_in && reg_addr_in == ccpu_pkg::OFS_FLAGS))
    |=> st_q.flag[0])
    else $error("event flag dropped without software clear");

  a_toggle_on_match: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (st_q.ctrl[0][3:0] == ccpu_pkg::MODE_TOGGLE && hit[0] && !reg_wr_in)
    |=> (st_q.out_latch[0] != $past(st_q.out_latch[0])) && st_q.flag[0])
    else $error("toggle mode did not toggle");

  a_set_on_match: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (st_q.ctrl[0][3:0] == ccpu_pkg::MODE_CMP_SET && hit[0] && !reg_wr_in)
    |=> st_q.out_latch[0] && st_q.flag[0])
    else $error("set mode did not drive high");

  a_clear_on_match: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (st_q.ctrl[1][3:0] == ccpu_pkg::MODE_CMP_CLR && hit[1] && !reg_wr_in)
    |=> !st_q.out_latch[1] && st_q.flag[1])
    else $error("clear mode did not drive low");

  a_trigger_clears_timer: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (st_q.ctrl[0][3:0] == ccpu_pkg::MODE_CMP_TRG && hit[0] && !use_second[0])
    |=> st_q.clr_first && match_trigger_out[0] ##1 !st_q.clr_first)
    else $error("trigger did not clear first timer once");

  a_adc_start: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (st_q.ctrl[1][3:0] == ccpu_pkg::MODE_CMP_TRG && hit[1] && adc_enable_in)
    |=> adc_start_out)
    else $error("unit two trigger did not start conversion");

  a_off_resets_unit: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (reg_wr_in && reg_addr_in == ccpu_pkg::OFS_CTRL_ONE
     && reg_wdata_in[3:0] == ccpu_pkg::MODE_OFF)
    |=> !st_q.out_latch[0] && st_q.presc[0] == 4'h0)
    else $error("disable did not reset unit");

  a_pwm_duty_load: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (st_q.ctrl[0][3:2] == 2'h3 && pwm_period_in)
    |=> pwm_duty_one_out == {$past(st_q.value[0][7:0]),
                             $past(st_q.ctrl[0][5:4])})
    else $error("duty not loaded at period event");

  a_reserved_bits_zero: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (reg_rd_in && reg_addr_in == ccpu_pkg::OFS_CTRL_TWO)
    |=> reg_rdata_out[7:6] == 2'h0)
    else $error("control bits 7:6 not zero");

endmodule // ccpu_top

`default_nettype wire

// [test/ccpu_pin_model.sv]
// Far-side source of pin events for both units.
// Assumes the bench asks for a flip with a one-clock pulse per unit.
`timescale 1ns/1ps
`default_nettype none

module ccpu_pin_model (
  input  wire logic       clk_in,
  input  wire logic [1:0] flip_in,
  output logic      [1:0] pin_out
);
  // Level stands until the next flip, so every level lasts several clocks
  initial pin_out = 2'b00;
  always @(posedge clk_in) begin
    pin_out <= pin_out ^ flip_in;
  end
endmodule // ccpu_pin_model

`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for ccpu_top: registers, capture and compare.
// Assumes the package and the pin model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_pend = 1'b0;
  logic [15:0] t1 = 16'h0000;
  logic [15:0] t3 = 16'h0000;
  logic [1:0]  tsel = 2'b00;
  logic [1:0]  flip = 2'b00;
  logic [1:0]  pd = 2'b11;
  logic [1:0]  pin, pout, trig;
  logic [7:0]  rdata;
  logic        clr1;
  logic        clr3;
  logic        adcs;
  logic        per = 1'b0;
  logic        tw1 = 1'b0;
  logic [1:0]  oe, flag, irq;
  logic [9:0]  duty1, duty2;
  logic [31:0] rnd = 32'h4FB1;
  logic [7:0]  expq[$];
  int          n_errors = 0;
  int          checks = 0;
  int          n_trig = 0;
  int          n_clr = 0;
  int          n_adc = 0;
  int          n_clr3 = 0;

  // Clock at 250 MHz
  always #2 clk = ~clk;

  ccpu_pin_model pm (.clk_in(clk), .flip_in(flip), .pin_out(pin));

  ccpu_top uut (
    .clk_in(clk), .rst_b_in(rst_b), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .first_timer_count_in(t1),
    .second_timer_count_in(t3), .first_timer_write_in(tw1),
    .second_timer_write_in(1'b0), .timebase_select_in(tsel),
    .pwm_period_in(per), .adc_enable_in(1'b1), .unit_pin_in(pin),
    .port_data_in(pd), .port_direction_in(2'b11), .unit_pin_out(pout),
    .unit_pin_oe_out(oe), .unit_event_flag_out(flag),
    .unit_event_irq_out(irq),
    .match_trigger_out(trig), .first_timer_clear_out(clr1),
    .second_timer_clear_out(clr3), .adc_start_out(adcs),
    .pwm_duty_one_out(duty1), .pwm_duty_two_out(duty2));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Notes the expected read data, the watcher compares it later
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    expq.push_back(e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // Pin pulses: rise then fall, each level held several clocks
  task automatic pulse(input logic [1:0] u, input int n);
    repeat (n) begin
      repeat (2) begin
        @(posedge clk);
        flip <= u;
        @(posedge clk);
        flip <= 2'b00;
        repeat (3) @(posedge clk);
      end
    end
  endtask

  task automatic complete_run;
    if (n_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watcher: read data and trigger pulses
  always @(posedge clk) begin
    rd_pend <= rd;
    n_trig <= n_trig + int'(trig[0]);
    n_clr <= n_clr + int'(clr1);
    n_adc <= n_adc + int'(adcs);
    n_clr3 <= n_clr3 + int'(clr3);
  end
  always @(negedge clk) begin
    if (rd_pend) chk(rdata, expq.pop_front());
  end

  initial begin
    #200000;
    n_errors++;
    complete_run;
  end

  initial begin
    int cnt[4];
    cnt = '{1, 1, 4, 16};
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(ccpu_pkg::OFS_HIGH_TWO, 8'h00);
    rd_reg(4'h9, 8'h00);
    wr_reg(ccpu_pkg::OFS_CTRL_TWO, 8'hF4);
    rd_reg(ccpu_pkg::OFS_CTRL_TWO, 8'h34);
    wr_reg(ccpu_pkg::OFS_LOW_ONE, 8'hA5);
    rd_reg(ccpu_pkg::OFS_LOW_ONE, 8'hA5);
    // Each capture mode, prescaler cleared by a disable first
    for (int m = 4; m < 8; m++) begin
      wr_reg(ccpu_pkg::OFS_CTRL_ONE, 8'h00);
      wr_reg(ccpu_pkg::OFS_CTRL_ONE, 8'(m));
      wr_reg(ccpu_pkg::OFS_FLAGS, 8'h03);
      pulse(2'b01, cnt[m-4] - 1);
      rd_reg(ccpu_pkg::OFS_FLAGS, 8'h00);
      rnd = lfsr(rnd);
      t1 <= rnd[15:0];
      pulse(2'b01, 1);
      rd_reg(ccpu_pkg::OFS_FLAGS, 8'h01);
      rd_reg(ccpu_pkg::OFS_LOW_ONE, t1[7:0]);
      rd_reg(ccpu_pkg::OFS_HIGH_ONE, t1[15:8]);
    end
    // Unit two on the second timer
    tsel <= 2'b01;
    rnd = lfsr(rnd);
    t3 <= rnd[15:0];
    wr_reg(ccpu_pkg::OFS_CTRL_TWO, 8'h05);
    wr_reg(ccpu_pkg::OFS_FLAGS, 8'h03);
    pulse(2'b10, 1);
    rd_reg(ccpu_pkg::OFS_FLAGS, 8'h02);
    rd_reg(ccpu_pkg::OFS_LOW_TWO, t3[7:0]);
    rd_reg(ccpu_pkg::OFS_HIGH_TWO, t3[15:8]);
    // Compare: start low, high on match; port latch differs from latch
    t1 <= 16'h0000;
    pd <= 2'b01;
    wr_reg(ccpu_pkg::OFS_LOW_ONE, 8'h34);
    wr_reg(ccpu_pkg::OFS_HIGH_ONE, 8'h12);
    wr_reg(ccpu_pkg::OFS_CTRL_ONE, 8'h08);
    wr_reg(ccpu_pkg::OFS_FLAGS, 8'h03);
    @(negedge clk);
    chk({7'h00, pout[0]}, 8'h00);
    @(posedge clk);
    t1 <= 16'h1234;
    repeat (3) @(negedge clk);
    chk({7'h00, pout[0]}, 8'h01);
    chk({6'h00, flag}, 8'h01);
    rd_reg(ccpu_pkg::OFS_FLAGS, 8'h01);
    // Toggle on a fresh match
    wr_reg(ccpu_pkg::OFS_CTRL_ONE, 8'h02);
    t1 <= 16'h0000;
    @(posedge clk);
    t1 <= 16'h1234;
    repeat (2) @(negedge clk);
    chk({7'h00, pout[0]}, 8'h00);
    @(posedge clk);
    // Match trigger clears the first timer once
    t1 <= 16'h0000;
    wr_reg(ccpu_pkg::OFS_CTRL_ONE, 8'h0B);
    t1 <= 16'h1234;
    repeat (4) @(posedge clk);
    chk(8'(n_trig), 8'h01);
    chk(8'(n_clr), 8'h01);
    // A timer write in the clear cycle beats the clear
    t1 <= 16'h0000;
    @(posedge clk);
    t1 <= 16'h1234;
    @(posedge clk);
    tw1 <= 1'b1;
    @(posedge clk);
    tw1 <= 1'b0;
    repeat (2) @(posedge clk);
    chk(8'(n_trig), 8'h02);
    chk(8'(n_clr), 8'h01);
    // Unit two: start high, low on match
    t3 <= 16'h0000;
    wr_reg(ccpu_pkg::OFS_LOW_TWO, 8'h78);
    wr_reg(ccpu_pkg::OFS_HIGH_TWO, 8'h56);
    wr_reg(ccpu_pkg::OFS_CTRL_TWO, 8'h09);
    @(negedge clk);
    chk({7'h00, pout[1]}, 8'h01);
    @(posedge clk);
    t3 <= 16'h5678;
    repeat (2) @(negedge clk);
    chk({7'h00, pout[1]}, 8'h00);
    // Unit two trigger clears the second timer and starts conversion
    wr_reg(ccpu_pkg::OFS_CTRL_TWO, 8'h0B);
    t3 <= 16'h0000;
    @(posedge clk);
    t3 <= 16'h5678;
    repeat (3) @(posedge clk);
    chk(8'(n_adc), 8'h01);
    chk(8'(n_clr3), 8'h01);
    // Interrupt line follows flag and enable
    wr_reg(ccpu_pkg::OFS_ENABLES, 8'h02);
    @(negedge clk);
    chk({6'h00, flag}, 8'h03);
    chk({6'h00, irq}, 8'h02);
    chk({6'h00, oe}, 8'h00);
    // PWM duty taken on the shared period event only
    wr_reg(ccpu_pkg::OFS_LOW_ONE, 8'hC3);
    wr_reg(ccpu_pkg::OFS_CTRL_ONE, 8'h2C);
    wr_reg(ccpu_pkg::OFS_LOW_TWO, 8'h5A);
    wr_reg(ccpu_pkg::OFS_CTRL_TWO, 8'h1F);
    @(negedge clk);
    chk(duty1[9:2], 8'h00);
    @(posedge clk);
    per <= 1'b1;
    @(posedge clk);
    per <= 1'b0;
    @(negedge clk);
    chk(duty1[9:2], 8'hC3);
    chk({6'h00, duty1[1:0]}, 8'h02);
    chk(duty2[9:2], 8'h5A);
    chk({6'h00, duty2[1:0]}, 8'h01);
    // Disabled unit hands the pin back to the port latch
    wr_reg(ccpu_pkg::OFS_CTRL_ONE, 8'h00);
    @(negedge clk);
    chk({7'h00, pout[0]}, 8'h01);
    rd_reg(ccpu_pkg::OFS_CTRL_ONE, 8'h00);
    repeat (3) @(posedge clk);
    complete_run;
  end
endmodule // tb_top

`default_nettype wire
